// *** src/watchdog_pkg.sv ***
package watchdog_pkg;

  // register byte addresses on the bus
  localparam logic [11:0] addr_watchdog_control = 12'h000;
  localparam logic [11:0] addr_option_control = 12'h004;
  localparam logic [11:0] addr_watchdog_status = 12'h008;

  // reset values
  localparam logic [7:0] watchdog_control_rst = 8'h08;
  localparam logic [7:0] option_control_rst = 8'hff;

  // field positions
  localparam int soft_on_bit = 0;
  localparam int period_lo_bit = 1;
  localparam int assign_bit = 3;
  localparam int period_codes = 12;

  // stage widths
  localparam int main_width = 16;
  localparam int shared_width = 8;

  // slow oscillator rate and derived tick spacing at 100 MHz
  localparam int slow_osc_hz = 31000;
  localparam int sys_clk_hz = 100000000;
  localparam int tick_cycles = sys_clk_hz / slow_osc_hz;

  typedef enum logic [1:0] {
    wd_idle,
    wd_run,
    wd_hold
  } wd_state_t;

  // core events into the watchdog
  typedef struct packed {
    logic clear_instr;
    logic sleep_instr;
    logic osc_fail;
    logic wake;
    logic crystal_wake;
    logic startup_busy;
  } core_event_t;

  // status seen by the core
  typedef struct packed {
    logic timeout_flag;
    logic powerdown_flag;
    logic reset_req;
    logic wake_req;
  } core_status_t;

endpackage : watchdog_pkg

// *** src/wd_ripple_counter.sv ***
`timescale 1ns/1ns
// free counter with synchronous clear, advanced on tick
module wd_ripple_counter
  import watchdog_pkg::*;
#(
  parameter int width = 8
)
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // control
  input wire logic clear_in,
  input wire logic tick_in,
  // count
  output logic [width-1:0] count_out,
  output logic carry_out
);

  typedef struct packed {
    logic [width-1:0] count;
  } cnt_state_t;

  cnt_state_t st_r;
  cnt_state_t st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    if (clear_in)
    begin
      st_nxt.count = '0;
    end
    else if (tick_in)
    begin
      st_nxt.count = st_r.count + 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign count_out = st_r.count;
  assign carry_out = tick_in && !clear_in && (&st_r.count);

endmodule : wd_ripple_counter

// *** src/watchdog_timer_unit.sv ***
`timescale 1ns/1ns
// Behaviour
// [R1] watchdog counts on ticks of the 31 kHz slow internal oscillator
// [R2] own 16-bit prescaler, tap chosen by four-bit period select
// [R3] 8-bit prescaler shared with general timer, assignment bit decides
// [R4] combined settings span about 1 ms to 268 seconds
// [R5] control register resets to 0x08: ratio 1:512, software enable off
// [R6] start-up count holds watchdog cleared; counting resumes when enabled
// [R7] fuse enable set keeps watchdog running, software bit ignored
// [R8] fuse clear: software bit starts and stops the watchdog
// [R9] cleared by fuse off, clear instruction, osc fail, non-crystal wake
// [R10] crystal wake holds watchdog cleared until start-up count ends
// [R11] period code 0 is 1:32, doubling to 1:65536; 12-15 reserved
// [R12] period select resets to code 0100, ratio 1:512
// [R13] bit 0 is software enable, resets to zero
// [R14] control bits 7 to 5 read as zero
// [R15] slow oscillator running flag not set by watchdog use
// [R16] sleep with watchdog on clears it, clears powerdown, sets timeout
// [R17] timeout flag cleared on wake caused by watchdog timeout
// [R18] timeout reset is internal only, master reset pin untouched
// [R19] watchdog cleared on every wake from sleep
// [R20] overflow resets a running device or wakes a sleeping one
module watchdog_timer_unit
  import watchdog_pkg::*;
#(
  parameter int tick_div = tick_cycles
)
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // configuration fuse
  input wire logic fuse_watchdog_on_in,
  // core events
  input wire core_event_t core_event_in,
  // core status and requests
  output core_status_t core_status_out,
  output logic slow_osc_running_flag_out,
  output logic master_reset_pin_drive_out
);

  typedef struct packed {
    wd_state_t state;
    logic [7:0] wdt_ctl;
    logic [7:0] opt_ctl;
    logic [15:0] div_cnt;
    logic [main_width-1:0] main_prev;
    logic [shared_width-1:0] shared_prev;
    logic timeout_flag;
    logic powerdown_flag;
    logic asleep;
    logic reset_req;
    logic wake_req;
    logic [31:0] rdata;
  } unit_state_t;

  unit_state_t st_r;
  unit_state_t st_nxt;

  logic tick;
  logic enabled;
  logic clear_cnt;
  logic [main_width-1:0] main_cnt;
  logic main_carry;
  logic [shared_width-1:0] shared_cnt;
  logic [3:0] period;
  logic tap_pulse;
  logic shared_used;
  logic [2:0] rate;
  logic overflow;
  logic [31:0] rd_mux;
  logic wr_ok;

  assign tick = (st_r.div_cnt == 16'(tick_div - 1)); // R1
  assign enabled = fuse_watchdog_on_in || st_r.wdt_ctl[soft_on_bit]; // R7 R8
  assign period = st_r.wdt_ctl[period_lo_bit +: 4]; // R11
  assign shared_used = st_r.opt_ctl[assign_bit]; // R3
  assign rate = st_r.opt_ctl[2:0];

  // counter cleared by every documented cause
  assign clear_cnt = !enabled || core_event_in.clear_instr // R9
    || core_event_in.osc_fail || core_event_in.wake // R9 R19
    || core_event_in.sleep_instr // R16
    || st_r.state != wd_run; // R6 R10

  wd_ripple_counter #(.width(main_width)) u_main
  (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .clear_in(clear_cnt),
    .tick_in(tick),
    .count_out(main_cnt),
    .carry_out(main_carry)
  );

  // tap of the 16-bit stage: code 0 divides by 32
  logic main_tap_rise;
  logic [4:0] tap_idx;
  assign tap_idx = 5'(period) + 5'd4;
  always_comb
  begin
    main_tap_rise = 1'b0;
    if (period < 4'(period_codes)) // R11
    begin
      main_tap_rise = st_r.main_prev[tap_idx[3:0]]
        && !main_cnt[tap_idx[3:0]];
      if (tap_idx[4])
      begin
        main_tap_rise = main_carry;
      end
    end
  end

  wd_ripple_counter #(.width(shared_width)) u_shared
  (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .clear_in(clear_cnt || !shared_used),
    .tick_in(main_tap_rise && shared_used),
    .count_out(shared_cnt),
    .carry_out()
  );

  // shared stage taps: rate n divides by 2^n
  logic shared_tap_rise;
  always_comb
  begin
    shared_tap_rise = st_r.shared_prev[rate - 3'd1]
      && !shared_cnt[rate - 3'd1];
    if (rate == 3'd0)
    begin
      shared_tap_rise = main_tap_rise;
    end
  end

  assign tap_pulse = shared_used ? shared_tap_rise : main_tap_rise; // R2 R3 R4
  assign overflow = tap_pulse && !clear_cnt; // R20

  assign wr_ok = psel && penable && pwrite;

  always_comb
  begin
    rd_mux = 32'h0;
    unique case (paddr)
      addr_watchdog_control: rd_mux = {27'h0, st_r.wdt_ctl[4:0]}; // R14
      addr_option_control: rd_mux = {24'h0, st_r.opt_ctl};
      addr_watchdog_status: rd_mux = {29'h0, enabled,
        st_r.timeout_flag, st_r.powerdown_flag};
      default: rd_mux = 32'h0;
    endcase
  end

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.reset_req = 1'b0;
    st_nxt.wake_req = 1'b0;
    st_nxt.div_cnt = tick ? 16'h0 : st_r.div_cnt + 16'h1;
    // edge history cleared with the stages so a clear is never a fall
    st_nxt.main_prev = clear_cnt ? '0 : main_cnt; // R9
    st_nxt.shared_prev = (clear_cnt || !shared_used) ? '0 : shared_cnt;
    if (psel && !penable)
    begin
      st_nxt.rdata = rd_mux;
    end
    if (wr_ok && paddr == addr_watchdog_control)
    begin
      st_nxt.wdt_ctl = {3'b000, pwdata[4:0]}; // R8 R13 R14
    end
    if (wr_ok && paddr == addr_option_control)
    begin
      st_nxt.opt_ctl = pwdata[7:0]; // R3
    end
    unique case (st_r.state)
      wd_idle:
      begin
        if (core_event_in.startup_busy)
        begin
          st_nxt.state = wd_hold; // R6
        end
        else if (enabled)
        begin
          st_nxt.state = wd_run;
        end
      end
      wd_run:
      begin
        if (!enabled)
        begin
          st_nxt.state = wd_idle; // R8
        end
        else if (core_event_in.wake && core_event_in.crystal_wake)
        begin
          st_nxt.state = wd_hold; // R10
        end
        else if (core_event_in.startup_busy)
        begin
          st_nxt.state = wd_hold; // R6
        end
      end
      wd_hold:
      begin
        if (!core_event_in.startup_busy)
        begin
          st_nxt.state = enabled ? wd_run : wd_idle; // R6
        end
      end
    endcase
    if (core_event_in.sleep_instr && enabled)
    begin
      st_nxt.asleep = 1'b1;
      st_nxt.powerdown_flag = 1'b0; // R16
      st_nxt.timeout_flag = 1'b1; // R16
    end
    if (core_event_in.wake)
    begin
      st_nxt.asleep = 1'b0;
    end
    if (overflow)
    begin
      if (st_r.asleep)
      begin
        st_nxt.wake_req = 1'b1; // R20
        st_nxt.timeout_flag = 1'b0; // R17
        st_nxt.asleep = 1'b0;
      end
      else
      begin
        st_nxt.reset_req = 1'b1; // R20
        st_nxt.timeout_flag = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      st_r <= '0;
      st_r.state <= wd_idle;
      st_r.wdt_ctl <= watchdog_control_rst; // R5 R12 R13
      st_r.opt_ctl <= option_control_rst;
      st_r.timeout_flag <= 1'b1;
      st_r.powerdown_flag <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign prdata = st_r.rdata;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign core_status_out = '{timeout_flag: st_r.timeout_flag,
    powerdown_flag: st_r.powerdown_flag,
    reset_req: st_r.reset_req, wake_req: st_r.wake_req};
  assign slow_osc_running_flag_out = 1'b0; // R15
  assign master_reset_pin_drive_out = 1'b0; // R18

  a_ctl_upper_zero: assert property (@(posedge sys_clk_in) // R14
    disable iff (rst_in) st_r.wdt_ctl[7:5] == 3'b000)
    else $error("control upper bits not zero");

  a_fuse_forces_on: assert property (@(posedge sys_clk_in) // R7
    disable iff (rst_in) fuse_watchdog_on_in
    && !core_event_in.startup_busy |=> st_r.state != wd_idle)
    else $error("fuse did not enable watchdog");

  a_hold_clears: assert property (@(posedge sys_clk_in) // R6
    disable iff (rst_in) st_r.state == wd_hold |-> ##1 main_cnt == '0)
    else $error("counter ran during start-up hold");

  a_clear_instr: assert property (@(posedge sys_clk_in) // R9
    disable iff (rst_in) core_event_in.clear_instr |=> main_cnt == '0)
    else $error("clear instruction missed");

  a_clear_no_tap: assert property (@(posedge sys_clk_in) // R9
    disable iff (rst_in) clear_cnt |=> !main_tap_rise)
    else $error("clear produced a false overflow");

  a_wake_clear: assert property (@(posedge sys_clk_in) // R19
    disable iff (rst_in) core_event_in.wake |=> main_cnt == '0)
    else $error("wake did not clear watchdog");

  a_sleep_flags: assert property (@(posedge sys_clk_in) // R16
    disable iff (rst_in) core_event_in.sleep_instr && enabled
    && !overflow |=> !st_r.powerdown_flag && st_r.timeout_flag)
    else $error("sleep flags wrong");

  a_reset_values: assert property (@(posedge sys_clk_in) // R5
    $fell(rst_in) |-> st_r.wdt_ctl == watchdog_control_rst)
    else $error("control reset value wrong");

  a_overflow_req: assert property (@(posedge sys_clk_in) // R20
    disable iff (rst_in) overflow |=> st_r.reset_req || st_r.wake_req)
    else $error("overflow gave no request");

  a_no_pin_drive: assert property (@(posedge sys_clk_in) // R18
    disable iff (rst_in) st_r.reset_req |-> !master_reset_pin_drive_out)
    else $error("timeout drove reset pin");

endmodule : watchdog_timer_unit

// *** testbench/testbench.sv ***
`timescale 1ns/1ns
module testbench;
  import watchdog_pkg::*;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic fuse_on = 1'b0;
  core_event_t ev = '0;
  core_status_t st;
  logic osc_flag;
  logic pin_drive;
  logic [31:0] q;
  bit hit;
  int fail_count = 0;
  int checks = 0;

  always #5 sys_clk_in = ~sys_clk_in;

  watchdog_timer_unit #(.tick_div(2)) i_dut (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(),
    .fuse_watchdog_on_in(fuse_on),
    .core_event_in(ev),
    .core_status_out(st),
    .slow_osc_running_flag_out(osc_flag),
    .master_reset_pin_drive_out(pin_drive)
  );

  task automatic summarize();
    if (fail_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge sys_clk_in);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk_in);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      fail_count++;
      summarize();
    end
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d}, q);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    apb(1'b0, a, 32'h0, q);
    chk(q, {24'h0, exp});
  endtask : rd

  // look for a request pulse within lim cycles
  task automatic wait_req(input bit wake, input int lim, input bit exp);
    hit = 1'b0;
    for (int i = 0; i < lim && !hit; i++)
    begin
      @(negedge sys_clk_in);
      hit = wake ? (st.wake_req === 1'b1) : (st.reset_req === 1'b1);
    end
    chk({31'h0, hit}, {31'h0, exp});
  endtask : wait_req

  task automatic pulse(input core_event_t m);
    @(posedge sys_clk_in);
    ev <= ev | m;
    @(posedge sys_clk_in);
    ev <= ev & ~m;
  endtask : pulse

  task automatic t_reset();
    rd(addr_watchdog_control, 8'h08);
    rd(addr_option_control, 8'hff);
    rd(addr_watchdog_status, 8'h03);
    chk({30'h0, st.timeout_flag, st.powerdown_flag}, 32'h3);
    chk({30'h0, osc_flag, pin_drive}, 32'h0);
  endtask : t_reset

  task automatic t_regs();
    wr(addr_watchdog_control, 8'hfe);
    rd(addr_watchdog_control, 8'h1e);
    wr(12'h00c, 8'h55);
    rd(12'h00c, 8'h00);
    wr(addr_option_control, 8'h00);
    rd(addr_option_control, 8'h00);
  endtask : t_regs

  task automatic t_soft();
    wr(addr_watchdog_control, 8'h01);
    wait_req(1'b0, 40, 1'b0);
    wait_req(1'b0, 60, 1'b1);
    wr(addr_watchdog_control, 8'h00);
    wr(addr_watchdog_control, 8'h03);
    wait_req(1'b0, 100, 1'b0);
    wait_req(1'b0, 80, 1'b1);
    wr(addr_watchdog_control, 8'h00);
    wait_req(1'b0, 300, 1'b0);
    wr(addr_watchdog_control, 8'h19);
    wait_req(1'b0, 300, 1'b0);
    wr(addr_watchdog_control, 8'h00);
    wr(addr_option_control, 8'h09);
    wr(addr_watchdog_control, 8'h01);
    wait_req(1'b0, 100, 1'b0);
    wait_req(1'b0, 80, 1'b1);
    wr(addr_watchdog_control, 8'h00);
    wr(addr_option_control, 8'h00);
  endtask : t_soft

  task automatic t_fuse();
    core_event_t m;
    m = '0;
    fuse_on <= 1'b1;
    wait_req(1'b0, 100, 1'b1);
    m.clear_instr = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      pulse(m);
      wait_req(1'b0, 40, 1'b0);
    end
    @(posedge sys_clk_in);
    ev.startup_busy <= 1'b1;
    wait_req(1'b0, 200, 1'b0);
    @(posedge sys_clk_in);
    ev.startup_busy <= 1'b0;
    wait_req(1'b0, 100, 1'b1);
  endtask : t_fuse

  task automatic t_sleep();
    core_event_t m;
    m = '0;
    m.sleep_instr = 1'b1;
    pulse(m);
    @(negedge sys_clk_in);
    chk({30'h0, st.timeout_flag, st.powerdown_flag}, 32'h2);
    wait_req(1'b1, 100, 1'b1);
    repeat (2) @(negedge sys_clk_in);
    chk({31'h0, st.timeout_flag}, 32'h0);
    chk({31'h0, pin_drive}, 32'h0);
    rd(addr_watchdog_status, 8'h04);
  endtask : t_sleep

  task automatic t_wake();
    core_event_t m;
    m = '0;
    m.clear_instr = 1'b1;
    pulse(m);
    wait_req(1'b0, 40, 1'b0);
    m = '0;
    m.osc_fail = 1'b1;
    pulse(m);
    wait_req(1'b0, 40, 1'b0);
    m = '0;
    m.wake = 1'b1;
    pulse(m);
    wait_req(1'b0, 40, 1'b0);
    @(posedge sys_clk_in);
    ev.crystal_wake <= 1'b1;
    ev.startup_busy <= 1'b1;
    pulse(m);
    wait_req(1'b0, 200, 1'b0);
    @(posedge sys_clk_in);
    ev.crystal_wake <= 1'b0;
    ev.startup_busy <= 1'b0;
    wait_req(1'b0, 100, 1'b1);
  endtask : t_wake

  initial
  begin
    repeat (6) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    t_reset();
    t_regs();
    t_soft();
    t_fuse();
    t_sleep();
    t_wake();
    summarize();
  end
endmodule : testbench
